//--- hw/fit_pins.sv
/*
  Pin logic for four general-purpose flag pins, four external interrupt
  request inputs and the timer-zero expired output, with an Avalon-MM slave.
  Assumes the timer logic gives a one-cycle expiry pulse on the core clock and
  that reset is held for at least four clock edges so straps settle.
*/
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module fit_pins (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire fit_pkg::fit_avm_req_s         avmReq,
  output logic                               avmWaitrequest,
  output logic [fit_pkg::DATA_W-1:0]         avmReaddata,
  input  wire logic [fit_pkg::NUM_FLAGS-1:0] gpConditionPinsIn,
  output fit_pkg::fit_flag_drv_s             gpConditionPinsDrv,
  output logic [fit_pkg::NUM_FLAGS-1:0]      gpCondition,
  input  wire logic [fit_pkg::NUM_IRQS-1:0]  extInterruptRequestPinsN,
  input  wire logic                          bootVectorsReady,
  output logic [fit_pkg::NUM_IRQS-1:0]       coreIrqReq,
  input  wire logic                          timerZeroExpire,
  input  wire logic                          timerZeroExpiredIn,
  output logic                               timerZeroExpiredOut,
  output logic                               timerZeroExpiredOe,
  input  wire logic                          irqBootStrapPin,
  output logic                               irqOut
);

  localparam int unsigned SYNC_W = fit_pkg::NUM_FLAGS + fit_pkg::NUM_IRQS + 2;

  logic [SYNC_W-1:0]                 syncIn;
  logic [SYNC_W-1:0]                 syncOut;
  logic [fit_pkg::NUM_FLAGS-1:0]     flagSync;
  logic [fit_pkg::NUM_IRQS-1:0]      irqSyncN;
  logic                              tmrPinSync;
  logic                              bootPinSync;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  assign syncIn = {irqBootStrapPin, timerZeroExpiredIn, extInterruptRequestPinsN, gpConditionPinsIn};

  fit_sync #(.W(SYNC_W)) uSync (
    .clk     (clk),
    .asyncIn (syncIn),
    .syncOut (syncOut)
  );

  assign flagSync    = syncOut[fit_pkg::NUM_FLAGS-1:0];
  assign irqSyncN    = syncOut[fit_pkg::NUM_FLAGS +: fit_pkg::NUM_IRQS];
  assign tmrPinSync  = syncOut[SYNC_W-2];
  assign bootPinSync = syncOut[SYNC_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [fit_pkg::NUM_FLAGS-1:0]  flagDir_q, flagDir_d;
  logic [fit_pkg::NUM_FLAGS-1:0]  flagOut_q, flagOut_d;
  logic [fit_pkg::NUM_IRQS-1:0]   irqSense_q, irqSense_d;
  logic [fit_pkg::NUM_IRQS-1:0]   irqEn_q, irqEn_d;
  logic                           bootDone_q, bootDone_d;
  logic [fit_pkg::NUM_EVENTS-1:0] evtStatus_q, evtStatus_d;
  logic [fit_pkg::NUM_EVENTS-1:0] evtEnable_q, evtEnable_d;
  logic                           waitReq_q, waitReq_d;
  logic [fit_pkg::DATA_W-1:0]     rdata_q, rdata_d;
  logic                           strapTmr_q, strapTmr_d;
  logic                           strapIrq_q, strapIrq_d;
  logic                           wrTake;
  logic [fit_pkg::DATA_W-1:0]     evtClear;
  logic [fit_pkg::NUM_EVENTS-1:0] events;

  // Accepted at the edge where waitrequest is seen low
  assign wrTake = avmReq.write && !waitReq_q;

  always_comb begin
    flagDir_d   = flagDir_q;
    flagOut_d   = flagOut_q;
    irqSense_d  = irqSense_q;
    irqEn_d     = irqEn_q;
    bootDone_d  = bootDone_q;
    evtEnable_d = evtEnable_q;
    evtClear    = '0;
    strapTmr_d  = strapTmr_q;
    strapIrq_d  = strapIrq_q;
    if (wrTake) begin
      unique case (avmReq.address)
        fit_pkg::OFS_FLAG_DIR:   flagDir_d   = avmReq.writedata[fit_pkg::NUM_FLAGS-1:0];
        fit_pkg::OFS_FLAG_OUT:   flagOut_d   = avmReq.writedata[fit_pkg::NUM_FLAGS-1:0];
        fit_pkg::OFS_IRQ_SENSE:  irqSense_d  = avmReq.writedata[fit_pkg::NUM_IRQS-1:0];
        fit_pkg::OFS_IRQ_EN:     irqEn_d     = avmReq.writedata[fit_pkg::NUM_IRQS-1:0];
        fit_pkg::OFS_INT_CLEAR:  evtClear    = avmReq.writedata;
        fit_pkg::OFS_INT_ENABLE: evtEnable_d = avmReq.writedata[fit_pkg::NUM_EVENTS-1:0];
        default: ;
      endcase
    end
    // One-shot boot enable; a software write in the same cycle is overridden
    if (strapIrq_q && bootVectorsReady && !bootDone_q) begin
      irqEn_d    = fit_pkg::IRQ_EN_BOOT;
      bootDone_d = 1'b1;
    end
    // Set wins over clear so an event landing on a clear is kept
    evtStatus_d = (evtStatus_q & ~evtClear[fit_pkg::NUM_EVENTS-1:0]) | events;
    if (srst) begin
      flagDir_d   = fit_pkg::FLAG_DIR_RST;
      flagOut_d   = fit_pkg::FLAG_OUT_RST;
      irqSense_d  = fit_pkg::IRQ_SENSE_RST;
      irqEn_d     = fit_pkg::IRQ_EN_RST;
      bootDone_d  = 1'b0;
      evtStatus_d = fit_pkg::EVT_RST;
      evtEnable_d = fit_pkg::EVT_RST;
      strapTmr_d  = tmrPinSync;
      strapIrq_d  = bootPinSync;
    end
  end

  always_ff @(posedge clk) begin
    flagDir_q   <= flagDir_d;
    flagOut_q   <= flagOut_d;
    irqSense_q  <= irqSense_d;
    irqEn_q     <= irqEn_d;
    bootDone_q  <= bootDone_d;
    evtStatus_q <= evtStatus_d;
    evtEnable_q <= evtEnable_d;
    strapTmr_q  <= strapTmr_d;
    strapIrq_q  <= strapIrq_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer

  always_comb begin
    waitReq_d = 1'b1;
    rdata_d   = rdata_q;
    if ((avmReq.read || avmReq.write) && waitReq_q) begin
      waitReq_d = 1'b0;
      rdata_d   = '0;
      if (avmReq.read) begin
        unique case (avmReq.address)
          fit_pkg::OFS_FLAG_DIR:   rdata_d[fit_pkg::NUM_FLAGS-1:0]  = flagDir_q;
          fit_pkg::OFS_FLAG_OUT:   rdata_d[fit_pkg::NUM_FLAGS-1:0]  = flagOut_q;
          fit_pkg::OFS_FLAG_IN:    rdata_d[fit_pkg::NUM_FLAGS-1:0]  = flagSync;
          fit_pkg::OFS_IRQ_SENSE:  rdata_d[fit_pkg::NUM_IRQS-1:0]   = irqSense_q;
          fit_pkg::OFS_IRQ_EN:     rdata_d[fit_pkg::NUM_IRQS-1:0]   = irqEn_q;
          fit_pkg::OFS_STRAPS: begin
            rdata_d[fit_pkg::STRAP_TMR_BIT] = strapTmr_q;
            rdata_d[fit_pkg::STRAP_IRQ_BIT] = strapIrq_q;
          end
          fit_pkg::OFS_INT_STATUS: rdata_d[fit_pkg::NUM_EVENTS-1:0] = evtStatus_q;
          fit_pkg::OFS_INT_ENABLE: rdata_d[fit_pkg::NUM_EVENTS-1:0] = evtEnable_q;
          default: ;
        endcase
      end
    end
    if (srst) begin
      waitReq_d = 1'b1;
      rdata_d   = '0;
    end
  end

  always_ff @(posedge clk) begin
    waitReq_q <= waitReq_d;
    rdata_q   <= rdata_d;
  end

  assign avmWaitrequest = waitReq_q;
  assign avmReaddata    = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt request sensing

  logic [fit_pkg::NUM_IRQS-1:0]  irqPrevN_q, irqPrevN_d;
  logic [fit_pkg::NUM_IRQS-1:0]  coreReq_q, coreReq_d;
  logic [fit_pkg::NUM_FLAGS-1:0] cond_q, cond_d;
  logic [fit_pkg::NUM_IRQS-1:0]  irqFall;

  // Pins are active low; an edge is the falling transition
  assign irqFall = irqPrevN_q & ~irqSyncN;

  always_comb begin
    irqPrevN_d = irqSyncN;
    cond_d     = flagSync;
    for (int i = 0; i < fit_pkg::NUM_IRQS; i++) begin
      coreReq_d[i] = irqEn_q[i] && (irqSense_q[i] ? irqFall[i] : !irqSyncN[i]);
    end
    if (srst) begin
      irqPrevN_d = '1;
      cond_d     = '0;
      coreReq_d  = '0;
    end
  end

  always_ff @(posedge clk) begin
    irqPrevN_q <= irqPrevN_d;
    coreReq_q  <= coreReq_d;
    cond_q     <= cond_d;
  end

  assign coreIrqReq             = coreReq_q;
  assign gpCondition            = cond_q;
  assign gpConditionPinsDrv     = '{out: flagOut_q, oe: flagDir_q};

  ////////////////////////////////////////////////////////////////////////////
  // Timer expired output and interrupt line

  logic [fit_pkg::TMR_CNT_W-1:0] tmrCnt_q, tmrCnt_d;
  logic                          tmrOut_q, tmrOut_d;
  logic                          tmrOe_q, tmrOe_d;
  logic                          irqLine_q, irqLine_d;

  assign events = {timerZeroExpire, irqFall};

  always_comb begin
    tmrCnt_d = tmrCnt_q;
    // A new expiry restarts the pulse rather than queueing a second one
    if (timerZeroExpire) begin
      tmrCnt_d = fit_pkg::TMR_CNT_W'(fit_pkg::TMR_PULSE_CYC);
    end else if (tmrCnt_q != '0) begin
      tmrCnt_d = tmrCnt_q - 1'b1;
    end
    tmrOut_d  = (tmrCnt_d != '0);
    tmrOe_d   = 1'b1;
    irqLine_d = |(evtStatus_d & evtEnable_d);
    if (srst) begin
      tmrCnt_d  = '0;
      tmrOut_d  = 1'b0;
      tmrOe_d   = 1'b0;
      irqLine_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    tmrCnt_q  <= tmrCnt_d;
    tmrOut_q  <= tmrOut_d;
    tmrOe_q   <= tmrOe_d;
    irqLine_q <= irqLine_d;
  end

  assign timerZeroExpiredOut = tmrOut_q;
  assign timerZeroExpiredOe  = tmrOe_q;
  assign irqOut              = irqLine_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  flag_dir_write_a: assert property (@(posedge clk) disable iff (srst)
    wrTake && avmReq.address == fit_pkg::OFS_FLAG_DIR |=>
      gpConditionPinsDrv.oe == $past(avmReq.writedata[fit_pkg::NUM_FLAGS-1:0]))
    else $error("flag direction does not follow the write");

  // The release edge still registers reset values, so start one edge later
  cond_follow_a: assert property (@(posedge clk) disable iff (srst)
    !srst |=> gpCondition == $past(flagSync))
    else $error("condition output does not follow synced flag");

  flag_reset_a: assert property (@(posedge clk)
    srst |=> gpConditionPinsDrv.oe == '0)
    else $error("flag drivers active after reset");

  level_irq_a: assert property (@(posedge clk) disable iff (srst)
    irqEn_q[2] && !irqSense_q[2] && !irqSyncN[2] |=> coreIrqReq[2])
    else $error("level request not raised");

  edge_irq_a: assert property (@(posedge clk) disable iff (srst)
    irqSense_q[1] && coreIrqReq[1] |=> !coreIrqReq[1] || $past(irqFall[1]))
    else $error("edge request longer than one cycle");

  irq_disabled_a: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) ##0 !strapIrq_q |-> irqEn_q == '0)
    else $error("interrupt inputs enabled after reset without boot strap");

  timer_pulse_a: assert property (@(posedge clk) disable iff (srst)
    timerZeroExpire ##1 !timerZeroExpire [*5] |-> ##1 !timerZeroExpiredOut)
    else $error("timer pulse has the wrong length");

  timer_high_a: assert property (@(posedge clk) disable iff (srst)
    timerZeroExpire |=> timerZeroExpiredOut [*2])
    else $error("timer pulse not driven");

  strap_no_drive_a: assert property (@(posedge clk)
    srst |=> !timerZeroExpiredOe)
    else $error("timer pin driven in reset");

  // Checked after release only: the synchroniser is unknown at power-up
  strap_sample_a: assert property (@(posedge clk)
    $fell(srst) |-> strapTmr_q == $past(tmrPinSync) && strapIrq_q == $past(bootPinSync))
    else $error("strap not taken at the last reset edge");

  sync_delay_a: assert property (@(posedge clk)
    !srst |-> ##2 flagSync == $past(gpConditionPinsIn, 2))
    else $error("flag synchroniser depth wrong");

  bus_answer_a: assert property (@(posedge clk) disable iff (srst)
    (avmReq.read || avmReq.write) && avmWaitrequest |=> !avmWaitrequest)
    else $error("bus answer later than one wait cycle");

  timer_pulse_c: cover property (@(posedge clk) disable iff (srst) timerZeroExpire ##1 timerZeroExpiredOut);
  edge_irq_c:    cover property (@(posedge clk) disable iff (srst) irqSense_q[0] && coreIrqReq[0]);
  boot_en_c:     cover property (@(posedge clk) disable iff (srst) !bootDone_q ##1 bootDone_q);
  irq_line_c:    cover property (@(posedge clk) disable iff (srst) $rose(irqOut));

endmodule

//--- hw/fit_pkg.sv
/*
  Shared constants and types for the flag, interrupt request and timer pin block:
  register offsets, field positions, reset values, timing counts and bus carriers.
  Assumes a 50 MHz core clock and a 32-bit Avalon-MM slave with byte addresses.
*/
package fit_pkg;

  localparam int unsigned NUM_FLAGS = 4;
  localparam int unsigned NUM_IRQS  = 4;
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FLAG_DIR   = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAG_OUT   = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAG_IN    = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SENSE  = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN     = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STRAPS     = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_INT_CLEAR  = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 6'h20;

  // Field positions
  localparam int unsigned STRAP_TMR_BIT   = 0;
  localparam int unsigned STRAP_IRQ_BIT   = 1;
  localparam int unsigned EVT_TMR_BIT     = 4;
  localparam int unsigned NUM_EVENTS      = 5;

  // Reset values
  localparam logic [NUM_FLAGS-1:0]  FLAG_DIR_RST   = 4'h0;
  localparam logic [NUM_FLAGS-1:0]  FLAG_OUT_RST   = 4'h0;
  localparam logic [NUM_IRQS-1:0]   IRQ_SENSE_RST  = 4'h0;
  localparam logic [NUM_IRQS-1:0]   IRQ_EN_RST     = 4'h0;
  localparam logic [NUM_IRQS-1:0]   IRQ_EN_BOOT    = 4'hf;
  localparam logic [NUM_EVENTS-1:0] EVT_RST        = 5'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TMR_PULSE_NS   = 100;
  localparam int unsigned TMR_PULSE_CYC  = (TMR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_CNT_W      = 3;

  typedef struct packed {
    logic                read;
    logic                write;
    logic [ADDR_W-1:0]   address;
    logic [DATA_W-1:0]   writedata;
  } fit_avm_req_s;

  typedef struct packed {
    logic [NUM_FLAGS-1:0] out;
    logic [NUM_FLAGS-1:0] oe;
  } fit_flag_drv_s;

endpackage

//--- hw/fit_sync.sv
/*
  Two-stage synchroniser for a bundle of asynchronous pin levels.
  Assumes each bit changes independently; no multi-bit coherence is given.
*/
`timescale 1ns/1ps
module fit_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // No reset on purpose: the stages must keep tracking the pins while reset
  // is held so that straps can be sampled then
  always_ff @(posedge clk) begin
    meta_q   <= asyncIn;
    stable_q <= meta_q;
  end

  assign syncOut = stable_q;

endmodule

//--- tb/fit_board.sv
/*
  Board model beside the flag, interrupt and timer pins: pull-ups, interrupt
  sources and the timer strap resistor.
  Assumes the bench commands the interrupt sources and the strap level.
*/
`timescale 1ns/1ps
module fit_board (
  input  wire fit_pkg::fit_flag_drv_s         flagDrv,
  output logic [fit_pkg::NUM_FLAGS-1:0]       flagPins,
  input  wire logic [fit_pkg::NUM_IRQS-1:0]   irqAssert,
  output logic [fit_pkg::NUM_IRQS-1:0]        irqPinsN,
  input  wire logic                           timerOut,
  input  wire logic                           timerOe,
  input  wire logic                           strapHigh,
  output logic                                timerPin
);
  // Undriven flags float to the pull-up level
  assign flagPins = (flagDrv.oe & flagDrv.out) | ~flagDrv.oe;
  assign irqPinsN = ~irqAssert;
  // Strap resistor sets the level whenever the pin is not driven
  assign timerPin = timerOe ? timerOut : strapHigh;
endmodule

//--- tb/test_fit_pins.sv
/*
  Self-checking bench for the flag, interrupt and timer pin block.
  Assumes the board model and an Avalon-MM master written as tasks here.
*/
`timescale 1ns/1ps
module test_fit_pins;
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } fit_row_s;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  fit_pkg::fit_avm_req_s  avmReq = '0;
  logic                   avmWaitrequest;
  logic [31:0]            avmReaddata;
  fit_pkg::fit_flag_drv_s flagDrv;
  logic [3:0]             flagPins;
  logic [3:0]             gpCondition;
  logic [3:0]             irqAssert = 4'h0;
  logic [3:0]             irqPinsN;
  logic                   bootReady = 1'b0;
  logic [3:0]             coreIrqReq;
  logic                   expire = 1'b0;
  logic                   timerPin;
  logic                   timerOut;
  logic                   timerOe;
  logic                   strapHigh = 1'b1;
  logic                   bootStrap = 1'b0;
  logic                   irqOut;
  logic [31:0]            q;
  int                     n_fail = 0;
  int                     checked = 0;
  int                     cycles = 0;
  // Strap at reset is 1 (timer) and 0 (irq boot), so STRAPS reads 1
  localparam fit_row_s ROWS [0:10] = '{
    '{1'b0, fit_pkg::OFS_FLAG_DIR, 32'h0, 32'h0},
    '{1'b1, fit_pkg::OFS_FLAG_DIR, 32'h5, 32'h5},
    '{1'b1, fit_pkg::OFS_FLAG_OUT, 32'ha, 32'ha},
    '{1'b0, fit_pkg::OFS_FLAG_IN, 32'h0, 32'ha},
    '{1'b1, fit_pkg::OFS_FLAG_IN, 32'h0, 32'ha},
    '{1'b1, fit_pkg::OFS_IRQ_SENSE, 32'h3, 32'h3},
    '{1'b0, fit_pkg::OFS_IRQ_EN, 32'h0, 32'h0},
    '{1'b1, fit_pkg::OFS_STRAPS, 32'h0, 32'h1},
    '{1'b1, 6'h24, 32'hff, 32'h0},
    '{1'b1, fit_pkg::OFS_INT_CLEAR, 32'h1f, 32'h0},
    '{1'b1, fit_pkg::OFS_INT_ENABLE, 32'h1f, 32'h1f}};

  always #10 clk = ~clk;

  fit_pins i_dut (.clk(clk), .srst(srst), .avmReq(avmReq), .avmWaitrequest(avmWaitrequest),
    .avmReaddata(avmReaddata), .gpConditionPinsIn(flagPins), .gpConditionPinsDrv(flagDrv),
    .gpCondition(gpCondition), .extInterruptRequestPinsN(irqPinsN), .bootVectorsReady(bootReady),
    .coreIrqReq(coreIrqReq), .timerZeroExpire(expire), .timerZeroExpiredIn(timerPin),
    .timerZeroExpiredOut(timerOut), .timerZeroExpiredOe(timerOe), .irqBootStrapPin(bootStrap),
    .irqOut(irqOut));
  fit_board i_board (.flagDrv(flagDrv), .flagPins(flagPins), .irqAssert(irqAssert),
    .irqPinsN(irqPinsN), .timerOut(timerOut), .timerOe(timerOe), .strapHigh(strapHigh),
    .timerPin(timerPin));

  task automatic conclude();
    $display("checked %0d, failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hung bench still reaches the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avmReq <= '{read: ~wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (avmWaitrequest !== 1'b0 && n < 40);
    if (n >= 40) chk(32'h1, 32'h0, "bus timeout");
    r = avmReaddata;
    avmReq <= '0;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Reset is seen by the design at five rising edges
  task automatic resetFor5();
    srst <= 1'b1;
    edges(4);
    chk(timerOe, 1'b0, "timer pin driven in reset");
    chk(flagDrv.oe, 4'h0, "flag driver on in reset");
    @(posedge clk);
    srst <= 1'b0;
    edges(2);
    chk(timerOe, 1'b1, "timer pin not driven after reset");
  endtask

  initial begin
    resetFor5();
    for (int i = 0; i <= 10; i++) begin
      if (ROWS[i].wr) bus(1'b1, ROWS[i].addr, ROWS[i].wdata, q);
      bus(1'b0, ROWS[i].addr, 32'h0, q);
      chk(q, ROWS[i].rexp, "register row");
    end
    chk(gpCondition, 4'ha, "flag condition");
    $display("test registers done");

    @(posedge clk);
    expire <= 1'b1;
    @(posedge clk);
    expire <= 1'b0;
    // Pulse stands from the edge that takes the expiry, for five cycles
    for (int i = 0; i < 6; i++) begin
      #1;
      chk(timerPin, (i < 5) ? 1'b1 : 1'b0, "timer pulse");
      @(posedge clk);
    end
    chk(irqOut, 1'b1, "timer interrupt");
    bus(1'b0, fit_pkg::OFS_INT_STATUS, 32'h0, q);
    chk(q, 32'h10, "timer status");
    bus(1'b1, fit_pkg::OFS_INT_CLEAR, 32'h10, q);
    edges(1);
    chk(irqOut, 1'b0, "interrupt after clear");
    $display("test timer done");

    // Bits 1:0 edge sensed, 3:2 level sensed
    bus(1'b1, fit_pkg::OFS_IRQ_EN, 32'hf, q);
    @(posedge clk);
    irqAssert <= 4'hf;
    edges(3);
    chk(coreIrqReq, 4'hf, "request on assert");
    edges(1);
    chk(coreIrqReq, 4'hc, "edge requests end");
    @(posedge clk);
    irqAssert <= 4'h0;
    edges(4);
    chk(coreIrqReq, 4'h0, "level requests end");
    bus(1'b0, fit_pkg::OFS_INT_STATUS, 32'h0, q);
    chk(q, 32'hf, "pin status");
    bus(1'b1, fit_pkg::OFS_IRQ_EN, 32'h0, q);
    @(posedge clk);
    irqAssert <= 4'hf;
    edges(5);
    chk(coreIrqReq, 4'h0, "disabled request");
    $display("test interrupts done");

    @(posedge clk);
    irqAssert <= 4'h0;
    strapHigh <= 1'b0;
    bootStrap <= 1'b1;
    resetFor5();
    bus(1'b0, fit_pkg::OFS_STRAPS, 32'h0, q);
    chk(q, 32'h2, "straps");
    bus(1'b0, fit_pkg::OFS_IRQ_EN, 32'h0, q);
    chk(q, 32'h0, "enable before vectors");
    bus(1'b0, fit_pkg::OFS_FLAG_DIR, 32'h0, q);
    chk(q, 32'h0, "direction after reset");
    @(posedge clk);
    bootReady <= 1'b1;
    edges(2);
    bus(1'b0, fit_pkg::OFS_IRQ_EN, 32'h0, q);
    chk(q, 32'hf, "boot enable");
    $display("test boot done");
    conclude();
  end
endmodule
